// >>> hw/sec_pkg.sv
// Purpose: Shared constants and types of the stop exit clock sequencer
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word a register
// Notes:   Reset-counter terms are in reset-counter clock ticks
package sec_pkg;

  // Register byte offsets
  localparam logic [7:0] SEC_CTRL_OFF    = 8'h00;
  localparam logic [7:0] SEC_STAT_OFF    = 8'h04;
  localparam logic [7:0] SEC_IRQ_STS_OFF = 8'h08;
  localparam logic [7:0] SEC_IRQ_CLR_OFF = 8'h0c;
  localparam logic [7:0] SEC_IRQ_EN_OFF  = 8'h10;

  // Control register fields
  localparam int SEC_LHD_BIT   = 0;
  localparam int SEC_CME_BIT   = 1;
  localparam int SEC_FORCED_CLOCK_MONITOR_ENABLE_BIT  = 2;
  localparam int SEC_DLY_BIT   = 3;
  localparam int SEC_PSTOP_BIT = 4;
  localparam int SEC_SLOW_LSB  = 8;
  localparam int SEC_SLOW_MSB  = 13;
  localparam logic [15:0] SEC_CTRL_RST = 16'h0000;

  // Interrupt status bits
  localparam int SEC_IRQ_CMR  = 0;
  localparam int SEC_IRQ_WAKE = 1;
  localparam int SEC_IRQ_LIMP = 2;
  localparam int SEC_IRQ_W    = 3;

  // Reset-counter terms and checks
  localparam logic [12:0] SEC_LONG_LAST  = 13'h0fff;
  localparam logic [12:0] SEC_SHORT_LAST = 13'h000f;
  localparam logic [12:0] SEC_CHECK_LOW  = 13'h0fff;
  localparam logic [8:0]  SEC_LIMP_PER   = 9'h002;

  localparam logic [1:0] SEC_OKAY   = 2'h0;
  localparam logic [1:0] SEC_SLVERR = 2'h2;

  typedef enum logic [1:0] {S_RUN, S_HALT, S_WAIT, S_LIMP} sec_state_t;

  typedef struct packed {
    logic halted;
    logic osc_run;
    logic vco_run;
    logic limp_home;
    logic on_crystal;
    logic cm_reset;
  } sec_clk_t;

  typedef struct packed {
    sec_state_t            state;
    logic                  pseudo;
    logic                  limp_wait;
    logic                  long_wait;
    logic [8:0]            div;
    logic                  tick;
    logic                  cnt_clr;
    logic [15:0]           ctrl;
    logic [SEC_IRQ_W-1:0]  irq_sts;
    logic [SEC_IRQ_W-1:0]  irq_en;
    logic                  irq;
    sec_clk_t              clk;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } sec_st_t;

  // Reset-counter clock period in aclk cycles from the slow divider
  function automatic logic [8:0] sec_reset_counter_clock_period(input logic [5:0] slow);
    sec_reset_counter_clock_period = (slow == 6'h00) ? 9'h002 : {1'b0, slow, 2'b00};
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] sec_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    sec_merge = old;
  endfunction

endpackage

// >>> hw/sec_rst_counter.sv
// Purpose: 13-stage reset counter stepped by the reset-counter clock
// Assumes: tick is a one-cycle enable, clear has priority
// Notes:   Wraps after 8192 ticks
`timescale 1ns/10ps
`default_nettype none
module sec_rst_counter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clear,
  input  wire logic        tick,
  output var  logic [12:0] count
);
  logic [12:0] count_nxt;

  always_comb begin
    count_nxt = count;
    if (clear) begin
      count_nxt = 13'h0000;
    end else if (tick) begin
      count_nxt = count + 13'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 13'h0000;
    end else begin
      count <= count_nxt;
    end
  end
endmodule // sec_rst_counter
`default_nettype wire

// >>> hw/sec_seq.sv
// Purpose: Sequences wake-up from halt and pseudo-halt low-power modes
// Assumes: All inputs synchronous to aclk; stop_req and wake_req pulses
// Notes:
// Overview of operation
// - Limp-home off with monitor on: stop instruction gives monitor reset.
// - Limp-home off, monitor off: only crystal activity wakes, no VCO.
// - Pseudo-halt, delay set: resume on crystal after 4096 counter ticks.
// - Pseudo-halt, limp-home off, delay clear: resume on crystal after 16 counter ticks.
// - With PLL supply up, external reset enters limp-home.
// - Full halt exit, no limp or monitor: 4096 ticks, slow-scaled.
// - Pseudo-halt, limp-home, delay: leave halt in limp-home after 4096 ticks unless crystal good.
// - Pseudo-halt enable makes stop instruction enter pseudo-halt.
// - In limp-home, monitor checked at count 4095, once per 8192 counter ticks.
`timescale 1ns/10ps
`default_nettype none
module sec_seq
  import sec_pkg::*;
#(
  parameter logic [8:0] LIMP_PERIOD = sec_pkg::SEC_LIMP_PER
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output var  logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output var  logic            s_axi_wready,
  output var  logic [1:0]      s_axi_bresp,
  output var  logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output var  logic            s_axi_arready,
  output var  logic [31:0]     s_axi_rdata,
  output var  logic [1:0]      s_axi_rresp,
  output var  logic            s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            stop_req,
  input  wire logic            wake_req,
  input  wire logic            ext_reset,
  input  wire logic            pll_supply,
  input  wire logic            crystal_good,
  output var  sec_pkg::sec_clk_t clk_ctl,
  output var  logic            irq
);
  import sec_pkg::*;

  sec_st_t     st_r;
  sec_st_t     st_nxt;
  logic [12:0] cnt;

  sec_rst_counter u_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (st_r.cnt_clr),
    .tick    (st_r.tick),
    .count   (cnt)
  );

  logic                 lhd_eff;
  logic                 cm_any;
  logic                 dly;
  logic [8:0]           period;
  logic [SEC_IRQ_W-1:0] ev;
  logic [SEC_IRQ_W-1:0] clr;
  logic                 wr_go;
  logic                 rd_go;
  logic                 term_hit;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.tick    = 1'b0;
    st_nxt.cnt_clr = 1'b0;
    st_nxt.clk.cm_reset = 1'b0;
    ev  = '0;
    clr = '0;
    lhd_eff = st_r.ctrl[SEC_LHD_BIT] | ~pll_supply;
    cm_any  = st_r.ctrl[SEC_CME_BIT] | st_r.ctrl[SEC_FORCED_CLOCK_MONITOR_ENABLE_BIT];
    dly     = st_r.ctrl[SEC_DLY_BIT];

    // Reset-counter clock enable
    if (st_r.clk.vco_run) begin
      period = LIMP_PERIOD;
    end else begin
      period = sec_reset_counter_clock_period(st_r.ctrl[SEC_SLOW_MSB:SEC_SLOW_LSB]);
    end
    if (st_r.state == S_WAIT || st_r.state == S_LIMP) begin
      if (st_r.div >= period - 9'h001) begin
        st_nxt.div  = 9'h000;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.div = st_r.div + 9'h001;
      end
    end else begin
      st_nxt.div = 9'h000;
    end

    term_hit = st_r.tick &&
      (cnt == (st_r.long_wait ? SEC_LONG_LAST : SEC_SHORT_LAST));

    unique case (st_r.state)
      S_RUN: begin
        if (stop_req) begin
          if (lhd_eff && cm_any) begin
            st_nxt.clk.cm_reset = 1'b1;
            ev[SEC_IRQ_CMR]     = 1'b1;
          end else begin
            st_nxt.state          = S_HALT;
            st_nxt.pseudo         = st_r.ctrl[SEC_PSTOP_BIT];
            st_nxt.clk.halted     = 1'b1;
            st_nxt.clk.osc_run    = st_r.ctrl[SEC_PSTOP_BIT];
            st_nxt.clk.vco_run    = 1'b0;
            st_nxt.clk.on_crystal = 1'b0;
          end
        end
      end
      S_HALT: begin
        if (wake_req && !lhd_eff) begin
          st_nxt.cnt_clr     = 1'b1;
          st_nxt.clk.vco_run = 1'b1;
          st_nxt.clk.osc_run = 1'b1;
          if (dly) begin
            st_nxt.state     = S_WAIT;
            st_nxt.limp_wait = 1'b1;
            st_nxt.long_wait = 1'b1;
          end else begin
            st_nxt.state         = S_LIMP;
            st_nxt.clk.halted    = 1'b0;
            st_nxt.clk.limp_home = 1'b1;
            ev[SEC_IRQ_LIMP]     = 1'b1;
            ev[SEC_IRQ_WAKE]     = 1'b1;
          end
        end else if (wake_req && crystal_good) begin
          st_nxt.state       = S_WAIT;
          st_nxt.cnt_clr     = 1'b1;
          st_nxt.limp_wait   = 1'b0;
          st_nxt.long_wait   = !st_r.pseudo || dly;
          st_nxt.clk.osc_run = 1'b1;
        end
      end
      S_WAIT: begin
        if (term_hit) begin
          st_nxt.clk.halted = 1'b0;
          ev[SEC_IRQ_WAKE]  = 1'b1;
          if (!st_r.limp_wait || crystal_good) begin
            st_nxt.state          = S_RUN;
            st_nxt.clk.on_crystal = 1'b1;
            st_nxt.clk.vco_run    = 1'b0;
          end else begin
            st_nxt.state         = S_LIMP;
            st_nxt.clk.limp_home = 1'b1;
            ev[SEC_IRQ_LIMP]     = 1'b1;
          end
        end
      end
      S_LIMP: begin
        if (st_r.tick && cnt == SEC_CHECK_LOW && crystal_good) begin
          st_nxt.state          = S_RUN;
          st_nxt.clk.limp_home  = 1'b0;
          st_nxt.clk.vco_run    = 1'b0;
          st_nxt.clk.on_crystal = 1'b1;
          ev[SEC_IRQ_LIMP]      = 1'b1;
        end
      end
    endcase

    // External reset overrides the sequence
    if (ext_reset) begin
      st_nxt.clk.halted     = 1'b0;
      st_nxt.clk.osc_run    = 1'b1;
      st_nxt.clk.cm_reset   = 1'b0;
      st_nxt.cnt_clr        = 1'b1;
      st_nxt.limp_wait      = 1'b0;
      if (pll_supply) begin
        st_nxt.state          = S_LIMP;
        st_nxt.clk.limp_home  = 1'b1;
        st_nxt.clk.vco_run    = 1'b1;
        st_nxt.clk.on_crystal = 1'b0;
        ev[SEC_IRQ_LIMP]      = 1'b1;
      end else begin
        st_nxt.state          = S_RUN;
        st_nxt.clk.limp_home  = 1'b0;
        st_nxt.clk.vco_run    = 1'b0;
        st_nxt.clk.on_crystal = 1'b1;
      end
    end

    // Write channel: address and data taken together
    wr_go = s_axi_awvalid && s_axi_wvalid && st_r.awready && st_r.wready;
    st_nxt.awready = !st_r.awready && !st_r.bvalid &&
                     s_axi_awvalid && s_axi_wvalid;
    st_nxt.wready  = st_nxt.awready;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = SEC_OKAY;
      unique case (s_axi_awaddr)
        SEC_CTRL_OFF: begin
          st_nxt.ctrl = 16'(sec_merge({16'h0000, st_r.ctrl},
                                      s_axi_wdata, s_axi_wstrb));
        end
        SEC_IRQ_CLR_OFF: begin
          clr = s_axi_wstrb[0] ? s_axi_wdata[SEC_IRQ_W-1:0] : '0;
        end
        SEC_IRQ_EN_OFF: begin
          st_nxt.irq_en = SEC_IRQ_W'(sec_merge({29'h0, st_r.irq_en},
                                               s_axi_wdata, s_axi_wstrb));
        end
        SEC_STAT_OFF, SEC_IRQ_STS_OFF: begin
          st_nxt.bresp = SEC_OKAY;
        end
        default: begin
          st_nxt.bresp = SEC_SLVERR;
        end
      endcase
    end

    // Sticky events, set wins over clear
    st_nxt.irq_sts = (st_r.irq_sts & ~clr) | ev;
    st_nxt.irq     = |(st_nxt.irq_sts & st_nxt.irq_en);

    // Read channel
    rd_go = s_axi_arvalid && st_r.arready;
    st_nxt.arready = !st_r.arready && !st_r.rvalid && s_axi_arvalid;
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = SEC_OKAY;
      unique case (s_axi_araddr)
        SEC_CTRL_OFF:    st_nxt.rdata = {16'h0000, st_r.ctrl};
        SEC_STAT_OFF:    st_nxt.rdata = {25'h0, st_r.state, pll_supply,
                                         st_r.clk.on_crystal,
                                         st_r.clk.limp_home,
                                         st_r.clk.osc_run,
                                         st_r.clk.halted};
        SEC_IRQ_STS_OFF: st_nxt.rdata = {29'h0, st_r.irq_sts};
        SEC_IRQ_CLR_OFF: st_nxt.rdata = 32'h0000_0000;
        SEC_IRQ_EN_OFF:  st_nxt.rdata = {29'h0, st_r.irq_en};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = SEC_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r                <= '0;
      st_r.state          <= S_RUN;
      st_r.ctrl           <= SEC_CTRL_RST;
      st_r.clk.osc_run    <= 1'b1;
      st_r.clk.on_crystal <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = st_r.rdata;
  assign clk_ctl       = st_r.clk;
  assign irq           = st_r.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cm_reset_a: assert property (
    (st_r.state == S_RUN && stop_req && !ext_reset &&
     (st_r.ctrl[SEC_LHD_BIT] || !pll_supply) &&
     (st_r.ctrl[SEC_CME_BIT] || st_r.ctrl[SEC_FORCED_CLOCK_MONITOR_ENABLE_BIT]))
    |=> clk_ctl.cm_reset && !clk_ctl.halted && st_r.state == S_RUN)
    else $error("monitor reset missing on stop");

  no_vco_wake_a: assert property (
    (st_r.state == S_HALT && !crystal_good && !ext_reset &&
     (st_r.ctrl[SEC_LHD_BIT] || !pll_supply))
    |=> st_r.state == S_HALT && !clk_ctl.vco_run)
    else $error("woke without crystal activity");

  long_wait_a: assert property (
    ($fell(clk_ctl.halted) && $past(st_r.state) == S_WAIT &&
     $past(st_r.long_wait) && !$past(ext_reset))
    |-> $past(cnt) == 13'h0fff)
    else $error("long wake wait not 4096 ticks");

  short_wait_a: assert property (
    ($fell(clk_ctl.halted) && $past(st_r.state) == S_WAIT &&
     !$past(st_r.long_wait) && !$past(ext_reset))
    |-> $past(cnt) == 13'h000f)
    else $error("short wake wait not 16 ticks");

  reset_limp_a: assert property (
    (ext_reset && pll_supply)
    |=> clk_ctl.limp_home && clk_ctl.vco_run ##1 st_r.state == S_LIMP)
    else $error("no limp-home after external reset");

  limp_exit_a: assert property (
    (st_r.state == S_WAIT && st_r.limp_wait && term_hit &&
     !crystal_good && !ext_reset)
    |=> clk_ctl.limp_home && !clk_ctl.halted && clk_ctl.osc_run)
    else $error("pseudo exit not in limp-home");

  pseudo_enter_a: assert property (
    (st_r.state == S_RUN && stop_req && !ext_reset && pll_supply &&
     !st_r.ctrl[SEC_LHD_BIT] && st_r.ctrl[SEC_PSTOP_BIT])
    |=> clk_ctl.halted && clk_ctl.osc_run && st_r.pseudo)
    else $error("pseudo-halt not entered");

  limp_check_a: assert property (
    (st_r.state == S_LIMP && st_r.tick && cnt == 13'h0fff &&
     crystal_good && !ext_reset)
    |=> st_r.state == S_RUN && !clk_ctl.limp_home && clk_ctl.on_crystal)
    else $error("limp-home monitor check missed");

  wait_clear_a: assert property (
    $rose(st_r.state == S_WAIT) |=> cnt == 13'h0000 && !st_r.tick)
    else $error("wake counter not cleared");

  wait_hold_a: assert property (
    (st_r.state == S_WAIT && !term_hit && !ext_reset)
    |=> st_r.state == S_WAIT && clk_ctl.halted)
    else $error("wake wait left before terminal count");

  full_halt_a: assert property (
    (st_r.state == S_HALT && !st_r.pseudo && wake_req && crystal_good &&
     !ext_reset && (st_r.ctrl[SEC_LHD_BIT] || !pll_supply))
    |=> st_r.state == S_WAIT && st_r.long_wait)
    else $error("full halt exit without long wait");

endmodule // sec_seq
`default_nettype wire

// >>> test/sec_xtal_model.sv
// Purpose: Crystal or external clock source seen by the clock monitor
// Assumes: Crystal runs only while osc_run; square wave runs always
// Notes:   fail holds any clock dead; crystal good after STARTUP cycles
`timescale 1ns/10ps
`default_nettype none
module sec_xtal_model #(
  parameter int STARTUP = 8
) (
  input  wire logic aclk,
  input  wire logic osc_run,
  input  wire logic ext_sq,
  input  wire logic fail,
  output var  logic crystal_good
);
  int unsigned age = 0;
  always @(posedge aclk) begin
    if (!osc_run || fail)
      age <= 0;
    else if (age < STARTUP)
      age <= age + 1;
    crystal_good <= !fail &&
                    (ext_sq || (age >= STARTUP && osc_run));
  end
endmodule // sec_xtal_model
`default_nettype wire

// >>> test/tb_stop_exit_clock_sequencer.sv
// Purpose: Self-checking bench of the stop exit clock sequencer
// Assumes: LIMP_PERIOD 2, crystal model with short start-up
// Notes:   Wake times counted from the edge that takes wake_req
`timescale 1ns/10ps
`default_nettype none
module tb_stop_exit_clock_sequencer;
  import sec_pkg::*;
  localparam int XT = 8;
  localparam logic [31:0] LHD = 32'h1 << SEC_LHD_BIT;
  localparam logic [31:0] CLOCK_MONITOR_ENABLE = 32'h1 << SEC_CME_BIT;
  localparam logic [31:0] FCM = 32'h1 << SEC_FORCED_CLOCK_MONITOR_ENABLE_BIT;
  localparam logic [31:0] DLY = 32'h1 << SEC_DLY_BIT;
  localparam logic [31:0] PST = 32'h1 << SEC_PSTOP_BIT;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        stop_req = 1'b0;
  logic        wake_req = 1'b0;
  logic        ext_reset = 1'b0;
  logic        pll_supply = 1'b1;
  logic        ext_sq = 1'b0;
  logic        fail = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, xgood, irq;
  logic [1:0]  bresp, rresp;
  logic [1:0]  wr_resp = 2'h0;
  logic [31:0] rdata;
  sec_clk_t    clk_ctl;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #10 aclk = ~aclk;

  sec_seq dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_req(stop_req), .wake_req(wake_req), .ext_reset(ext_reset),
    .pll_supply(pll_supply), .crystal_good(xgood),
    .clk_ctl(clk_ctl), .irq(irq)
  );
  sec_xtal_model #(.STARTUP(XT)) xtal_u (
    .aclk(aclk), .osc_run(clk_ctl.osc_run), .ext_sq(ext_sq),
    .fail(fail), .crystal_good(xgood)
  );

  function automatic logic [31:0] b(input logic v);
    b = {31'h0, v};
  endfunction
  task automatic cmp(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmp_rng(input string w, input int lo, input int g);
    comparisons++;
    if (g < lo || g > lo + 8) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", w, lo, lo + 8, g);
    end
  endtask
  task automatic done(input string s);
    $display("Test %s done", s);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse_stop;
    @(posedge aclk);
    stop_req <= 1'b1;
    @(posedge aclk);
    stop_req <= 1'b0;
    cyc(2);
  endtask
  task automatic pulse_wake;
    @(posedge aclk);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
  endtask
  task automatic wake_time(output int n);
    pulse_wake();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (clk_ctl.halted === 1'b1 && n < 20000);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(SEC_CTRL_OFF, d, r);
    cmp("ctrl reset", 32'h0, d);
    axi_rd(SEC_STAT_OFF, d, r);
    cmp("stat reset", 32'h1a, d);
    axi_rd(8'h20, d, r);
    cmp("unmapped resp", {30'h0, SEC_SLVERR}, {30'h0, r});
    axi_wr(8'h20, 32'h1);
    cmp("unmapped wr", {30'h0, SEC_SLVERR}, {30'h0, wr_resp});
    axi_wr(SEC_IRQ_EN_OFF, 32'h0);
    cmp("wr okay", {30'h0, SEC_OKAY}, {30'h0, wr_resp});
    axi_rd(SEC_CTRL_OFF, d, r);
    cmp("ctrl kept", 32'h0, d);
    done("regs");
  endtask
  task automatic t_mon;
    logic [31:0] m[2];
    logic [31:0] d;
    logic [1:0]  r;
    logic        seen;
    m = '{CLOCK_MONITOR_ENABLE, FCM};
    foreach (m[i]) begin
      axi_wr(SEC_IRQ_EN_OFF, 32'h0);
      axi_wr(SEC_CTRL_OFF, LHD | PST | m[i]);
      @(posedge aclk);
      stop_req <= 1'b1;
      @(posedge aclk);
      stop_req <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
        @(posedge aclk);
        seen = seen | (clk_ctl.cm_reset === 1'b1);
      end
      cmp("monitor reset", 32'h1, b(seen));
      cmp("no halt", 32'h0, b(clk_ctl.halted));
      cmp("irq masked", 32'h0, b(irq));
      axi_wr(SEC_IRQ_EN_OFF, 32'h1);
      cyc(2);
      cmp("irq set", 32'h1, b(irq));
      axi_wr(SEC_IRQ_CLR_OFF, 32'h1);
      axi_rd(SEC_IRQ_STS_OFF, d, r);
      cmp("irq status", 32'h0, d & 32'h1);
      cmp("irq clear", 32'h0, b(irq));
    end
    done("monitor");
  endtask
  task automatic t_short;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    ext_sq <= 1'b1;
    fail <= 1'b1;
    axi_wr(SEC_CTRL_OFF, LHD | PST);
    pulse_stop();
    cmp("pseudo halted", 32'h1, b(clk_ctl.halted));
    cmp("pseudo osc", 32'h1, b(clk_ctl.osc_run));
    pulse_wake();
    cyc(8);
    cmp("dead wake", 32'h1, b(clk_ctl.halted));
    cmp("no vco", 32'h0, b(clk_ctl.vco_run));
    fail <= 1'b0;
    cyc(XT + 4);
    wake_time(n);
    cmp_rng("short wait", 2 * 16, n);
    cyc(2);
    cmp("short crystal", 32'h1, b(clk_ctl.on_crystal));
    cmp("short vco", 32'h0, b(clk_ctl.vco_run));
    axi_rd(SEC_IRQ_STS_OFF, d, r);
    cmp("wake flag", 32'h1, (d >> SEC_IRQ_WAKE) & 32'h1);
    axi_wr(SEC_IRQ_CLR_OFF, 32'h7);
    ext_sq <= 1'b0;
    done("short");
  endtask
  task automatic t_exit(input string nm, input logic [31:0] c,
                        input int lo, input logic osc);
    int n;
    axi_wr(SEC_CTRL_OFF, c);
    pulse_stop();
    cmp("halt osc", b(osc), b(clk_ctl.osc_run));
    wake_time(n);
    cmp_rng(nm, lo, n);
    cyc(2);
    cmp("on crystal", 32'h1, b(clk_ctl.on_crystal));
    done(nm);
  endtask
  task automatic t_limp;
    int          t0;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    fail <= 1'b1;
    axi_wr(SEC_CTRL_OFF, PST | DLY);
    pulse_stop();
    cmp("limp osc", 32'h1, b(clk_ctl.osc_run));
    wake_time(n);
    t0 = cycles;
    cmp_rng("limp wait", 2 * 4096, n);
    cyc(2);
    cmp("limp mode", 32'h1, b(clk_ctl.limp_home));
    axi_rd(SEC_IRQ_STS_OFF, d, r);
    cmp("limp flag", 32'h1, (d >> SEC_IRQ_LIMP) & 32'h1);
    fail <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (clk_ctl.limp_home === 1'b1 && n < 17000);
    cmp_rng("limp check", 2 * 8192 - 4, cycles - t0);
    cyc(2);
    cmp("limp exit", 32'h1, b(clk_ctl.on_crystal));
    done("limp");
  endtask
  task automatic t_rst;
    ext_reset <= 1'b1;
    cyc(XT + 4);
    ext_reset <= 1'b0;
    cyc(3);
    cmp("reset limp", 32'h1, b(clk_ctl.limp_home));
    pll_supply <= 1'b0;
    ext_reset <= 1'b1;
    cyc(XT + 4);
    ext_reset <= 1'b0;
    cyc(3);
    cmp("reset no pll", 32'h0, b(clk_ctl.limp_home));
    done("reset");
  endtask

  task automatic end_sim;
    $display("Comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      $display("Error timeout expected end seen %0d cycles", cycles);
      end_sim();
    end
  end

  initial begin
    cyc(2);
    aresetn <= 1'b1;
    t_regs();
    t_mon();
    t_short();
    t_exit("pseudo delay", LHD | PST | DLY, 2 * 4096, 1'b1);
    ext_sq <= 1'b1;
    t_exit("full halt", LHD | (32'h1 << SEC_SLOW_LSB), 4 * 4096, 1'b0);
    ext_sq <= 1'b0;
    t_limp();
    t_rst();
    end_sim();
  end
endmodule // tb_stop_exit_clock_sequencer
`default_nettype wire
